//--- design/rpc_counter.sv
// reciprocal period counter core with apb register access.
// assumes sig_in and arm_req are synchronous to sys_clk.
//
// Summary of operation
// R01: result always derived from a period measurement; after a switch to the conventional gate it comes from a timed count
// R02: frequency is reciprocal of period, no timed count; the conventional gate (R10, R11) is a timed count
// R03: separate time and event tallies, combined later
// R04: input edges open and close the main gate
// R05: single period: clocks over exactly one input cycle
// R06: period equals clock count times clock period
// R07: averaging keeps gate open across several cycles
// R08: average period is clock time over cycles
// R09: frequency averaging returns reciprocal of that quotient
// R10: too fast input switches to conventional counting
// R11: conventional gate is a fixed timed interval
// R12: external arm: start on first cycle after arm
// R13: automatic arm: start on first arriving cycle
// R14: pending arm held until gate opens, then cleared
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ns
module rpc_counter #(
  parameter int gate_us = 1000, // conventional gate length in us
  parameter int min_clk_per_cyc = 2 // below this, input is too fast
) (
  input wire logic sys_clk, // 100 MHz reference clock
  input wire logic rstn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready, always high
  output logic pslverr, // apb error on unmapped address
  input wire logic sig_in, // measured signal
  input wire logic arm_req, // external arm pulse
  output logic gate_open // main gate level
);
  import rpc_pkg::*;

  localparam int gate_cyc = gate_us * RPC_NS_PER_US / RPC_CLK_PERIOD_NS;

  // ==========================================================
  // elaboration checks
  initial begin
    if (gate_cyc < 1) $error("gate_us too small");
    if (min_clk_per_cyc < 1) $error("min_clk_per_cyc must be >= 1");
  end

  rpc_state_type state;
  logic [3:0] ctrl;
  logic [31:0] ncyc;
  logic [31:0] events;
  logic [31:0] ticks;
  logic [31:0] result;
  logic done_flag;
  logic conv_used;
  logic ovf;
  logic arm_pend;
  logic sig_q;
  logic edge_in;
  logic armed;
  logic wr_en;
  logic start_req;
  logic fast;
  logic div_start;
  logic div_done;
  logic [RPC_NUM_W-1:0] div_quot;
  rpc_div_req_type div_req;

  // ==========================================================
  // input edge detection and arming qualification
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sig_q <= 1'b0;
    end else begin
      sig_q <= sig_in;
    end
  end

  assign edge_in = sig_in && !sig_q;
  // pending arm is registered so an edge in the arm cycle itself
  // does not count as the first cycle after arming
  assign armed = ctrl[RPC_CTRL_EXT] ? arm_pend : 1'b1; // R12 R13
  assign wr_en = psel && penable && pwrite;
  assign start_req = wr_en && (paddr == RPC_CTRL_ADDR) &&
                     pwdata[RPC_CTRL_START];
  // fewer clocks than min_clk_per_cyc per input cycle: too fast
  assign fast = ({32'h0, ticks} <
                 ({32'h0, events} * 64'(min_clk_per_cyc)));

  // ==========================================================
  // arm request latch; a new request wins over the clear
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      arm_pend <= 1'b0;
    end else if (arm_req) begin
      arm_pend <= 1'b1; // R12
    end else if (state == RPC_ARM && edge_in && ctrl[RPC_CTRL_EXT]) begin
      arm_pend <= 1'b0; // R14
    end
  end

  // ==========================================================
  // measurement sequencer
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state <= RPC_IDLE;
    end else begin
      case (state)
        RPC_IDLE: begin
          if (start_req) begin
            state <= RPC_ARM;
          end
        end
        RPC_ARM: begin
          if (edge_in && armed) begin
            state <= RPC_PGATE; // R04
          end
        end
        RPC_PGATE: begin
          if (edge_in && events + 32'h1 >= ncyc) begin
            state <= RPC_CALC; // R07
          end
        end
        RPC_CALC: begin
          if (div_start && fast && ctrl[RPC_CTRL_AUTO] && !conv_used) begin
            state <= RPC_CONV; // R10
          end else if (div_done) begin
            state <= RPC_IDLE;
          end
        end
        RPC_CONV: begin
          if (ticks == 32'(gate_cyc)) begin
            state <= RPC_CALC; // R11
          end
        end
        default: begin
          state <= RPC_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // time and event tallies, both running while the gate is open
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ticks <= '0;
      events <= '0;
    end else if (state == RPC_IDLE && start_req) begin
      ticks <= '0;
      events <= '0;
    end else if (state == RPC_ARM && edge_in && armed) begin
      ticks <= '0; // R05
      events <= '0;
    end else if (state == RPC_PGATE) begin
      ticks <= ticks + 32'h1; // R03
      if (edge_in) begin
        events <= events + 32'h1; // R05
      end
    end else if (state == RPC_CALC && div_start && fast &&
                 ctrl[RPC_CTRL_AUTO] && !conv_used) begin
      ticks <= '0; // gate opens at an arbitrary moment
      events <= '0;
    end else if (state == RPC_CONV && ticks != 32'(gate_cyc)) begin
      ticks <= ticks + 32'h1; // R11
      if (edge_in) begin
        events <= events + 32'h1;
      end
    end
  end

  // main gate output follows the sequencer
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      gate_open <= 1'b0;
    end else begin
      gate_open <= (state == RPC_PGATE && !(edge_in &&
                    events + 32'h1 >= ncyc)) ||
                   (state == RPC_ARM && edge_in && armed) ||
                   (state == RPC_CONV && ticks != 32'(gate_cyc));
    end
  end

  // ==========================================================
  // divider request: period in ps or frequency in hz
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      div_start <= 1'b0;
    end else begin
      div_start <= ((state == RPC_PGATE && edge_in &&
                     events + 32'h1 >= ncyc) ||
                    (state == RPC_CONV && ticks == 32'(gate_cyc)));
    end
  end

  always_comb begin
    if (ctrl[RPC_CTRL_FREQ]) begin
      div_req.num = {32'h0, events} * RPC_CLK_HZ; // R09
      div_req.den = ticks; // R02
    end else begin
      div_req.num = {32'h0, ticks} * RPC_CLK_PERIOD_PS; // R06 R08
      div_req.den = events; // R08
    end
  end

  rpc_divider rpc_divider_i (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .start(div_start && !(fast && ctrl[RPC_CTRL_AUTO] && !conv_used)),
    .req(div_req),
    .busy(),
    .done(div_done),
    .quot(div_quot)
  );

  // ==========================================================
  // result capture; overflow saturates rather than wrapping
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      result <= '0;
      ovf <= 1'b0;
    end else if (div_done) begin
      result <= (|div_quot[RPC_NUM_W-1:RPC_DEN_W]) ? 32'hFFFF_FFFF :
                div_quot[RPC_DEN_W-1:0]; // R01
      ovf <= (|div_quot[RPC_NUM_W-1:RPC_DEN_W]) || (div_req.den == 32'h0);
    end
  end

  // mode flag: set when the conventional gate is taken
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      conv_used <= 1'b0;
    end else if (state == RPC_IDLE && start_req) begin
      conv_used <= 1'b0;
    end else if (state == RPC_CONV) begin
      conv_used <= 1'b1; // R10
    end
  end

  // done is sticky; completion wins over a write-one clear
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      done_flag <= 1'b0;
    end else if (div_done) begin
      done_flag <= 1'b1;
    end else if (wr_en && paddr == RPC_STAT_ADDR &&
                 pwdata[RPC_STAT_DONE]) begin
      done_flag <= 1'b0;
    end
  end

  // ==========================================================
  // software registers; start bit is a pulse and is not stored
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= RPC_CTRL_RST;
      ncyc <= RPC_NCYC_RST;
    end else if (wr_en && state == RPC_IDLE) begin
      if (paddr == RPC_CTRL_ADDR) begin
        ctrl <= {pwdata[RPC_CTRL_AUTO:RPC_CTRL_FREQ], 1'b0};
      end else if (paddr == RPC_NCYC_ADDR) begin
        ncyc <= (pwdata == 32'h0) ? RPC_NCYC_RST : pwdata;
      end
    end
  end

  // ==========================================================
  // apb read path, registered during the setup phase
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= 1'b0;
      prdata <= '0;
      if (paddr == RPC_CTRL_ADDR) begin
        prdata <= {28'h0, ctrl};
      end else if (paddr == RPC_NCYC_ADDR) begin
        prdata <= ncyc;
      end else if (paddr == RPC_STAT_ADDR) begin
        prdata <= {27'h0, arm_pend, ovf, conv_used, done_flag,
                   state != RPC_IDLE};
      end else if (paddr == RPC_EVT_ADDR) begin
        prdata <= events;
      end else if (paddr == RPC_TIME_ADDR) begin
        prdata <= ticks;
      end else if (paddr == RPC_RES_ADDR) begin
        prdata <= result;
      end else begin
        pslverr <= 1'b1;
      end
    end
  end

  assign pready = 1'b1; // zero wait states

  // ==========================================================
  // assertions
  property p_arm_clear;
    @(posedge sys_clk) disable iff (!rstn)
    (state == RPC_ARM && edge_in && ctrl[RPC_CTRL_EXT] && arm_pend &&
     !arm_req) |=> !arm_pend;
  endproperty
  a_arm_clear: assert property (p_arm_clear) // R14
    else $error("pending arm not cleared at gate open");

  property p_ext_wait;
    @(posedge sys_clk) disable iff (!rstn)
    (state == RPC_ARM && ctrl[RPC_CTRL_EXT] && !arm_pend) |=>
    state != RPC_PGATE;
  endproperty
  a_ext_wait: assert property (p_ext_wait) // R12
    else $error("gate opened without arm");

  property p_auto_arm;
    @(posedge sys_clk) disable iff (!rstn)
    (state == RPC_ARM && edge_in && !ctrl[RPC_CTRL_EXT]) |=>
    (state == RPC_PGATE && gate_open);
  endproperty
  a_auto_arm: assert property (p_auto_arm) // R13
    else $error("auto arm missed first cycle");

  property p_open_edge;
    @(posedge sys_clk) disable iff (!rstn)
    (state == RPC_PGATE && $past(state) == RPC_ARM) |-> $past(edge_in);
  endproperty
  a_open_edge: assert property (p_open_edge) // R04
    else $error("gate opened without input edge");

  property p_close_count;
    @(posedge sys_clk) disable iff (!rstn)
    (state == RPC_PGATE ##1 state == RPC_CALC) |-> events == ncyc;
  endproperty
  a_close_count: assert property (p_close_count) // R07
    else $error("gate closed at wrong cycle count");

  property p_tick_run;
    @(posedge sys_clk) disable iff (!rstn)
    (state == RPC_PGATE ##1 state == RPC_PGATE) |->
    ticks == $past(ticks) + 32'h1;
  endproperty
  a_tick_run: assert property (p_tick_run) // R03
    else $error("time tally not running with gate");

  property p_conv_len;
    @(posedge sys_clk) disable iff (!rstn)
    (state == RPC_CONV ##1 state == RPC_CALC) |->
    ticks == 32'(gate_cyc);
  endproperty
  a_conv_len: assert property (p_conv_len) // R11
    else $error("conventional gate length wrong");

  property p_switch;
    @(posedge sys_clk) disable iff (!rstn)
    (state == RPC_CALC && div_start && fast && ctrl[RPC_CTRL_AUTO] &&
     !conv_used) |=> state == RPC_CONV;
  endproperty
  a_switch: assert property (p_switch) // R10
    else $error("fast input did not switch mode");

  property p_freq_num;
    @(posedge sys_clk) disable iff (!rstn)
    (div_start && ctrl[RPC_CTRL_FREQ]) |->
    (div_req.den == ticks && div_req.num == {32'h0, events} * RPC_CLK_HZ);
  endproperty
  a_freq_num: assert property (p_freq_num) // R09
    else $error("frequency quotient operands wrong");

endmodule

//--- design/rpc_pkg.sv
// package of the reciprocal period counter: register map, field
// positions, reset values, timing constants, states and carriers.
// assumes a 100 MHz reference clock and a 32-bit apb register bus.
package rpc_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] RPC_CTRL_ADDR = 8'h00;
  localparam logic [7:0] RPC_NCYC_ADDR = 8'h04;
  localparam logic [7:0] RPC_STAT_ADDR = 8'h08;
  localparam logic [7:0] RPC_EVT_ADDR = 8'h0C;
  localparam logic [7:0] RPC_TIME_ADDR = 8'h10;
  localparam logic [7:0] RPC_RES_ADDR = 8'h14;

  // ==========================================================
  // control fields
  localparam int RPC_CTRL_START = 0;
  localparam int RPC_CTRL_FREQ = 1;
  localparam int RPC_CTRL_EXT = 2;
  localparam int RPC_CTRL_AUTO = 3;
  localparam logic [3:0] RPC_CTRL_RST = 4'h8;
  localparam logic [31:0] RPC_NCYC_RST = 32'h0000_0001;

  // ==========================================================
  // status fields
  localparam int RPC_STAT_BUSY = 0;
  localparam int RPC_STAT_DONE = 1;
  localparam int RPC_STAT_CONV = 2;
  localparam int RPC_STAT_OVF = 3;
  localparam int RPC_STAT_ARM = 4;

  // ==========================================================
  // timing of the reference clock
  localparam int RPC_CLK_PERIOD_NS = 10;
  localparam int RPC_NS_PER_US = 1000;
  localparam logic [63:0] RPC_CLK_PERIOD_PS = 64'h0000_0000_0000_2710;
  localparam logic [63:0] RPC_CLK_HZ = 64'h0000_0000_05F5_E100;

  // ==========================================================
  // divider geometry
  localparam int RPC_NUM_W = 64;
  localparam int RPC_DEN_W = 32;
  localparam logic [6:0] RPC_DIV_LAST = 7'h3F;

  // ==========================================================
  // measurement sequencer states, gray along the usual path
  typedef enum logic [2:0] {
    RPC_IDLE = 3'b000,
    RPC_ARM = 3'b001,
    RPC_PGATE = 3'b011,
    RPC_CALC = 3'b010,
    RPC_CONV = 3'b110
  } rpc_state_type;

  // request to the divider
  typedef struct packed {
    logic [RPC_NUM_W-1:0] num;
    logic [RPC_DEN_W-1:0] den;
  } rpc_div_req_type;

endpackage

//--- design/rpc_divider.sv
// restoring divider used to form period and frequency quotients.
// assumes a start pulse only while idle; one quotient bit per clock.
`timescale 1ns/1ns
module rpc_divider (
  input wire logic sys_clk, // reference clock
  input wire logic rstn, // async reset, active low
  input wire logic start, // one-cycle start pulse
  input wire rpc_pkg::rpc_div_req_type req, // dividend and divisor
  output logic busy, // division in progress
  output logic done, // one-cycle pulse, quot valid
  output logic [rpc_pkg::RPC_NUM_W-1:0] quot // quotient
);
  import rpc_pkg::*;

  logic [RPC_DEN_W:0] rem;
  logic [RPC_DEN_W-1:0] den;
  logic [6:0] cnt;
  logic [RPC_DEN_W:0] shifted;

  // partial remainder with next dividend bit brought down
  assign shifted = {rem[RPC_DEN_W-1:0], quot[RPC_NUM_W-1]};

  // ==========================================================
  // iteration; a zero divisor yields all ones, flagged by caller
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rem <= '0;
      den <= '0;
      quot <= '0;
      cnt <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        rem <= '0;
        den <= req.den;
        quot <= req.num;
        cnt <= '0;
        busy <= 1'b1;
      end else if (busy) begin
        if (shifted >= {1'b0, den}) begin
          rem <= shifted - {1'b0, den};
          quot <= {quot[RPC_NUM_W-2:0], 1'b1};
        end else begin
          rem <= shifted;
          quot <= {quot[RPC_NUM_W-2:0], 1'b0};
        end
        cnt <= cnt + 7'h01;
        if (cnt == RPC_DIV_LAST) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule

//--- verification/rpc_sig_src.sv
// partner model: measured signal source and external arm source.
// assumes the bench sets period and run while a measurement is idle.
`timescale 1ns/1ns
module rpc_sig_src (
  input wire logic sys_clk, // reference clock
  input wire logic run, // signal runs while high
  input wire logic [7:0] per, // period in clocks, 2 or more
  output logic sig_in, // measured signal
  output logic arm_req // external arm pulse
);
  logic [7:0] cnt;

  initial begin
    cnt = 8'h00;
    sig_in = 1'b0;
    arm_req = 1'b0;
  end

  // ==========================================================
  // signal: one rise per period; rests low while stopped so that
  // a restart always begins with a fresh rising edge
  always @(posedge sys_clk) begin
    if (!run) begin
      cnt <= 8'h00;
      sig_in <= 1'b0;
    end else begin
      cnt <= (cnt >= per - 8'h01) ? 8'h00 : cnt + 8'h01;
      sig_in <= (cnt < per / 8'h02);
    end
  end

  // ==========================================================
  // one-cycle arm pulse, called while the signal is stopped and low
  task automatic fire_arm();
    arm_req <= 1'b1;
    @(posedge sys_clk);
    arm_req <= 1'b0;
  endtask
endmodule

//--- verification/tb_top.sv
// testbench of the reciprocal period counter: apb master, queue of
// expected notes, output watchers and measurement scenarios.
// assumes the partner model drives sig_in and arm_req.
`timescale 1ns/1ns
module tb_top;
  import rpc_pkg::*;
  typedef struct packed {
    logic chk;
    logic err;
    logic [31:0] data;
  } rpc_note_type;
  localparam int GATE_US = 1;
  localparam int MINC = 3;
  localparam int GATE_CYC = GATE_US * RPC_NS_PER_US / RPC_CLK_PERIOD_NS;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic sig_in;
  logic arm_req;
  logic gate_open;
  logic run = 1'b0;
  logic [7:0] per = 8'h04;
  logic gprev = 1'b0;
  logic gchk = 1'b0;
  logic f;
  int gcnt = 0;
  int err_count = 0;
  int tests_run = 0;
  int n;
  int p;
  integer seed = 32'h568B9248;
  rpc_note_type note_q[$];
  int gate_q[$];

  always #5 sys_clk = ~sys_clk;

  rpc_counter #(.gate_us(GATE_US), .min_clk_per_cyc(MINC)) rpc_counter_i (
    .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sig_in(sig_in),
    .arm_req(arm_req), .gate_open(gate_open));

  rpc_sig_src rpc_sig_src_i (.sys_clk(sys_clk), .run(run), .per(per),
    .sig_in(sig_in), .arm_req(arm_req));

  // ==========================================================
  // comparison, verdict and quotient helpers
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (err_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // results wider than the register saturate
  function automatic logic [31:0] quo(input logic [63:0] a, b);
    logic [63:0] q;
    q = a / b;
    return (q > 64'hFFFFFFFF) ? 32'hFFFFFFFF : q[31:0];
  endfunction

  // ==========================================================
  // apb master: holds the request until pready at an edge, then
  // lets one edge pass idle so back-to-back calls never collide
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, input logic chk, input logic [31:0] exp,
      input logic err);
    note_q.push_back({chk, err, exp});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  // ==========================================================
  // watchers: oldest note per finished transfer, gate length per gate
  always @(posedge sys_clk) begin
    rpc_note_type nt;
    if (psel && penable && pready && note_q.size() > 0) begin
      nt = note_q.pop_front();
      check(pslverr, nt.err);
      if (nt.chk && !pwrite) check(prdata, nt.data);
    end
  end

  always @(posedge sys_clk) begin
    if (gate_open === 1'b1) gcnt <= gcnt + 1;
    if (gprev && !gate_open) begin
      if (gchk && gate_q.size() > 0) check(gcnt, gate_q.pop_front());
      gcnt <= 0;
    end
    gprev <= gate_open;
  end

  // ==========================================================
  // one measurement; expected tallies and result from the rules
  task automatic measure(input logic [31:0] ctrl, input int n, p);
    logic [63:0] t;
    logic [63:0] e;
    logic conv;
    conv = ctrl[RPC_CTRL_AUTO] && (p < MINC);
    t = conv ? GATE_CYC : n * p;
    e = conv ? GATE_CYC / p : n;
    per <= p[7:0];
    run <= 1'b0;
    gchk <= !conv;
    if (!conv) gate_q.push_back(n * p);
    apb(1'b1, RPC_NCYC_ADDR, n, 1'b0, 32'h0, 1'b0);
    apb(1'b1, RPC_CTRL_ADDR, ctrl | 32'h1, 1'b0, 32'h0, 1'b0);
    if (ctrl[RPC_CTRL_EXT]) begin
      // no arm yet: a running signal must not open the gate
      run <= 1'b1;
      repeat (4 * p) @(posedge sys_clk);
      apb(1'b0, RPC_STAT_ADDR, 0, 1'b1, 32'h1, 1'b0);
      check(gate_open, 1'b0);
      run <= 1'b0;
      apb(1'b1, RPC_NCYC_ADDR, n + 1, 1'b0, 32'h0, 1'b0);
      apb(1'b0, RPC_NCYC_ADDR, 0, 1'b1, n, 1'b0);
      rpc_sig_src_i.fire_arm();
      apb(1'b0, RPC_STAT_ADDR, 0, 1'b1, 32'h11, 1'b0);
    end
    run <= 1'b1;
    repeat (4) @(posedge sys_clk);
    if (n * p > 6) check(gate_open, 1'b1);
    rd = 32'h0;
    while (rd[RPC_STAT_DONE] !== 1'b1)
      apb(1'b0, RPC_STAT_ADDR, 0, 1'b0, 32'h0, 1'b0);
    apb(1'b0, RPC_STAT_ADDR, 0, 1'b1, {29'h0, conv, 2'b10}, 1'b0);
    apb(1'b0, RPC_EVT_ADDR, 0, 1'b1, e[31:0], 1'b0);
    apb(1'b0, RPC_TIME_ADDR, 0, 1'b1, t[31:0], 1'b0);
    apb(1'b0, RPC_RES_ADDR, 0, 1'b1, ctrl[RPC_CTRL_FREQ] ?
      quo(e * RPC_CLK_HZ, t) : quo(t * RPC_CLK_PERIOD_PS, e), 1'b0);
    apb(1'b1, RPC_STAT_ADDR, 32'h2, 1'b0, 32'h0, 1'b0);
    // the mode flag stands until the next start
    apb(1'b0, RPC_STAT_ADDR, 0, 1'b1, {29'h0, conv, 2'b00}, 1'b0);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    // reset values, unmapped place, zero cycle count
    apb(1'b0, RPC_CTRL_ADDR, 0, 1'b1, RPC_CTRL_RST, 1'b0);
    apb(1'b0, RPC_NCYC_ADDR, 0, 1'b1, RPC_NCYC_RST, 1'b0);
    for (int i = 0; i < 4; i++)
      apb(1'b0, RPC_STAT_ADDR + 8'(4 * i), 0, 1'b1, 32'h0, 1'b0);
    apb(1'b0, 8'h18, 0, 1'b1, 32'h0, 1'b1);
    apb(1'b1, 8'h18, 32'hFFFF, 1'b0, 32'h0, 1'b1);
    apb(1'b1, RPC_NCYC_ADDR, 32'h0, 1'b0, 32'h0, 1'b0);
    apb(1'b0, RPC_NCYC_ADDR, 0, 1'b1, 32'h1, 1'b0);
    // single period in both result kinds, then random averaging
    measure(32'h8, 1, 10);
    measure(32'hA, 1, 10);
    repeat (6) begin
      n = 2 + $unsigned($random(seed)) % 7;
      p = 4 + $unsigned($random(seed)) % 16;
      f = ($random(seed) % 2) != 0;
      measure({28'h0, 1'b1, 1'b0, f, 1'b0}, n, p);
    end
    // too fast input: switch on and off; then external arming
    measure(32'h8, 4, 2);
    measure(32'hA, 4, 2);
    measure(32'h0, 4, 2);
    measure(32'hC, 3, 7);
    measure(32'hE, 2, 5);
    apb(1'b0, RPC_CTRL_ADDR, 0, 1'b1, 32'hE, 1'b0);
    final_report();
  end

  // watchdog well beyond the expected run length
  initial begin
    repeat (30000) @(posedge sys_clk);
    err_count++;
    final_report();
  end
endmodule
